// ### rtl/sac_pkg.sv
package sac_pkg;
  // Register indices on the plain register port
  localparam logic [0:0] ADDR_CTRL = 1'h0;
  localparam logic [0:0] ADDR_RESULT = 1'h1;
  // Control/status field positions
  localparam int BIT_DONE = 7;
  localparam int BIT_RC = 6;
  localparam int BIT_ON = 5;
  localparam int CH_MSB = 3;
  // Reset values
  localparam logic [3:0] RST_CHANNEL = 4'h0;
  // Conversion timing in converter clocks
  localparam int CONV_CYCLES = 32;
  localparam int SAMPLE_CYCLES = 24;
  // Channel codes
  localparam logic [3:0] CH_PIN_LAST = 4'h5;
  localparam logic [3:0] CH_REF_HIGH = 4'h8;
  localparam logic [3:0] CH_REF_LOW = 4'h9;
  localparam logic [3:0] CH_REF_MID = 4'ha;
  localparam logic [3:0] CH_RESERVED = 4'hb;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_RESOLVE
  } sac_phase_e;
endpackage

// ### rtl/sac_adc_control.sv
module sac_adc_control (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [0:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic rc_clock_tick_in,
  input wire logic comparator_high_in,
  input wire logic wait_mode_in,
  input wire logic [7:0] port_c_pin_level_in,
  input wire logic [7:0] port_c_dir_in,
  output logic [7:0] port_c_digital_read_out,
  output logic [7:0] port_c_analog_select_out,
  output logic [7:0] port_c_port_enable_out,
  output logic reference_pins_claimed_out,
  output logic converter_power_out,
  output logic charge_pump_on_out,
  output logic rc_oscillator_on_out,
  output logic sample_hold_out,
  output logic [7:0] dac_code_out,
  output logic [3:0] analog_mux_select_out,
  output logic force_zero_result_out
);

  typedef struct packed {
    logic conversion_complete_flag;
    logic rc_clock_select;
    logic converter_on;
    logic [3:0] channel_select;
    sac_pkg::sac_phase_e phase;
    logic [4:0] cycle_count;
    logic [7:0] sar_code;
    logic [7:0] trial_bit;
    logic [7:0] rdata;
    logic [7:0] digital_read;
  } sac_state_s;

  // The result holds no reset, so it sits outside the reset state
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic result_load;
  sac_state_s state_ff;
  sac_state_s nxt_state;
  logic conv_tick;
  logic ctrl_write;
  logic result_read;
  logic pin_selected;
  logic [7:0] pin_mask;
  logic [7:0] resolved_code;

  // RC select steers which clock paces the conversion
  assign conv_tick = state_ff.rc_clock_select ? rc_clock_tick_in : 1'b1;
  assign ctrl_write = reg_wr_in && (reg_addr_in == sac_pkg::ADDR_CTRL);
  assign result_read = reg_rd_in && (reg_addr_in == sac_pkg::ADDR_RESULT);
  assign pin_selected = state_ff.converter_on && (state_ff.channel_select <= sac_pkg::CH_PIN_LAST);
  assign pin_mask = pin_selected ? (8'h01 << state_ff.channel_select[2:0]) : 8'h00;

  // The comparator decides the last trial bit, so fold it into the stored code
  always_comb
  begin
    resolved_code = state_ff.sar_code;
    if (!comparator_high_in)
    begin
      resolved_code = state_ff.sar_code & ~state_ff.trial_bit;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    result_load = 1'b0;
    nxt_result = resolved_code;
    // Wait mode deliberately plays no part in the sequence
    if (conv_tick && state_ff.converter_on)
    begin
      case (state_ff.phase)
        sac_pkg::SAC_SAMPLE:
        begin
          nxt_state.cycle_count = state_ff.cycle_count + 5'h01;
          if (state_ff.cycle_count == 5'(sac_pkg::SAMPLE_CYCLES - 1))
          begin
            nxt_state.phase = sac_pkg::SAC_RESOLVE;
            nxt_state.sar_code = 8'h80;
            nxt_state.trial_bit = 8'h80;
          end
        end
        sac_pkg::SAC_RESOLVE:
        begin
          nxt_state.cycle_count = state_ff.cycle_count + 5'h01;
          nxt_state.trial_bit = state_ff.trial_bit >> 1;
          nxt_state.sar_code = resolved_code | (state_ff.trial_bit >> 1);
          if (state_ff.cycle_count == 5'(sac_pkg::CONV_CYCLES - 1))
          begin
            // Overwrite regardless of the flag; next conversion starts at once
            result_load = 1'b1;
            nxt_result = (state_ff.channel_select == sac_pkg::CH_RESERVED) ? 8'h00 : resolved_code;
            nxt_state.conversion_complete_flag = 1'b1;
            nxt_state.phase = sac_pkg::SAC_SAMPLE;
            nxt_state.cycle_count = 5'h00;
            nxt_state.sar_code = 8'h00;
            nxt_state.trial_bit = 8'h00;
          end
        end
        default:
        begin
          nxt_state.phase = sac_pkg::SAC_IDLE;
        end
      endcase
    end
    // A result read clears the flag; a completion in the same cycle wins
    if (result_read && !result_load)
    begin
      nxt_state.conversion_complete_flag = 1'b0;
    end
    if (ctrl_write)
    begin
      nxt_state.rc_clock_select = reg_wdata_in[sac_pkg::BIT_RC];
      nxt_state.converter_on = reg_wdata_in[sac_pkg::BIT_ON];
      nxt_state.channel_select = reg_wdata_in[sac_pkg::CH_MSB:0];
      // A write restarts the conversion, so a completion here is discarded
      nxt_state.conversion_complete_flag = 1'b0;
      result_load = 1'b0;
      nxt_state.cycle_count = 5'h00;
      nxt_state.sar_code = 8'h00;
      nxt_state.trial_bit = 8'h00;
      nxt_state.phase = reg_wdata_in[sac_pkg::BIT_ON] ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
    end
    nxt_state.rdata = 8'h00;
    if (reg_rd_in)
    begin
      if (reg_addr_in == sac_pkg::ADDR_CTRL)
      begin
        nxt_state.rdata = {state_ff.conversion_complete_flag, state_ff.rc_clock_select,
                           state_ff.converter_on, 1'b0, state_ff.channel_select};
      end
      else
      begin
        nxt_state.rdata = result_ff;
      end
    end
    // Selected analog pin reads zero to avoid mixed use
    nxt_state.digital_read = port_c_pin_level_in & ~pin_mask;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_ff <= '{conversion_complete_flag: 1'b0, rc_clock_select: 1'b0, converter_on: 1'b0,
                    channel_select: sac_pkg::RST_CHANNEL, phase: sac_pkg::SAC_IDLE,
                    cycle_count: 5'h00, sar_code: 8'h00, trial_bit: 8'h00,
                    rdata: 8'h00, digital_read: 8'h00};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // No reset on the result register
  always_ff @(posedge clk_in)
  begin
    if (result_load)
    begin
      result_ff <= nxt_result;
    end
  end

  assign reg_rdata_out = state_ff.rdata;
  assign port_c_digital_read_out = state_ff.digital_read;
  // Selected pin goes to the analog path; pins 6 and 7 become references
  assign port_c_analog_select_out = pin_mask;
  assign reference_pins_claimed_out = state_ff.converter_on;
  assign port_c_port_enable_out = ~(pin_mask | {{2{state_ff.converter_on}}, 6'h00});
  assign converter_power_out = state_ff.converter_on;
  assign charge_pump_on_out = state_ff.converter_on;
  assign rc_oscillator_on_out = state_ff.converter_on && state_ff.rc_clock_select;
  assign sample_hold_out = (state_ff.phase == sac_pkg::SAC_SAMPLE);
  // Code 8 compares against full scale: inputs at or above it end all ones
  assign dac_code_out = state_ff.sar_code;
  // Codes b..f route the low reference
  assign analog_mux_select_out = (state_ff.channel_select > sac_pkg::CH_REF_MID) ? sac_pkg::CH_REF_LOW
                                                                               : state_ff.channel_select;
  assign force_zero_result_out = (state_ff.channel_select == sac_pkg::CH_RESERVED);

endmodule // sac_adc_control

// ### verif/sac_analog_model.sv
module sac_analog_model (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic rc_on_in,
  input wire logic [3:0] mux_in,
  input wire logic [7:0] dac_in,
  input wire logic [7:0] level_in,
  output logic comparator_out,
  output logic tick_out
);
  logic [7:0] lvl;
  logic [1:0] div_ff;
  always_comb
  begin
    case (mux_in)
      4'h8: lvl = 8'hff;
      4'ha: lvl = 8'h80;
      default: lvl = (mux_in < 4'h6) ? level_in ^ {4'h0, mux_in} : 8'h00;
    endcase
    comparator_out = lvl >= dac_in;
  end
  // Oscillator at a quarter of the system clock, stopped while switched off
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in)
      div_ff <= 2'h0;
    else if (rc_on_in)
      div_ff <= div_ff + 2'h1;
  assign tick_out = rc_on_in && div_ff == 2'h3;
endmodule // sac_analog_model

// ### verif/sac_adc_control_monitor.sv
module sac_adc_control_monitor (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic reg_wr_in,
  input wire logic [0:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] port_c_analog_select_out,
  input wire logic [7:0] port_c_port_enable_out,
  input wire logic reference_pins_claimed_out,
  input wire logic converter_power_out,
  input wire logic charge_pump_on_out,
  input wire logic rc_oscillator_on_out,
  input wire logic sample_hold_out,
  input wire logic [3:0] analog_mux_select_out,
  input wire logic force_zero_result_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  chk_pump_power: assert property (charge_pump_on_out == converter_power_out)
    else $error("pump differs from power");
  chk_refs_claimed: assert property (converter_power_out |->
    reference_pins_claimed_out && port_c_port_enable_out[7:6] == 2'h0)
    else $error("reference pins not claimed");
  chk_rc_gated: assert property (rc_oscillator_on_out |-> converter_power_out)
    else $error("rc running while off");
  chk_analog_owned: assert property ((port_c_analog_select_out & port_c_port_enable_out) == 8'h00)
    else $error("analog pin left to port");
  chk_pin_onehot: assert property (port_c_analog_select_out != 8'h00 |->
    converter_power_out && port_c_analog_select_out == 8'h01 << analog_mux_select_out)
    else $error("wrong pin selected");
  chk_mux_reserved: assert property (force_zero_result_out |-> analog_mux_select_out == 4'h9)
    else $error("reserved code not on low ref");
  chk_start_sample: assert property (reg_wr_in && reg_addr_in == 1'h0 && reg_wdata_in[5] |=>
    sample_hold_out [*8])
    else $error("no sampling after start");
  chk_off_idle: assert property (!converter_power_out |->
    !sample_hold_out && port_c_analog_select_out == 8'h00)
    else $error("activity while off");
  cover property ($rose(sample_hold_out));
  cover property (rc_oscillator_on_out && sample_hold_out);
  cover property (force_zero_result_out);
endmodule // sac_adc_control_monitor

bind sac_adc_control sac_adc_control_monitor u_sac_adc_control_monitor (.clk_in, .arst_n_in, .reg_wr_in,
  .reg_addr_in, .reg_wdata_in, .port_c_analog_select_out, .port_c_port_enable_out, .reference_pins_claimed_out,
  .converter_power_out, .charge_pump_on_out, .rc_oscillator_on_out, .sample_hold_out, .analog_mux_select_out,
  .force_zero_result_out);

// ### verif/sac_adc_control_tb.sv
module sac_adc_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [0:0] addr = 1'h0;
  logic [7:0] wdata = 8'h00, pins = 8'hd7, level = 8'h3c, rdata, dig, dac, d;
  logic wr = 1'b0, rd = 1'b0, wmode = 1'b0, cmp, tick, rco;
  logic [3:0] mux;
  int n_errors = 0, checks_done = 0;
  sac_adc_control u_sac_adc_control (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .rc_clock_tick_in(tick),
    .comparator_high_in(cmp), .wait_mode_in(wmode), .port_c_pin_level_in(pins), .port_c_dir_in(8'h00),
    .port_c_digital_read_out(dig), .port_c_analog_select_out(), .port_c_port_enable_out(),
    .reference_pins_claimed_out(), .converter_power_out(), .charge_pump_on_out(), .rc_oscillator_on_out(rco),
    .sample_hold_out(), .dac_code_out(dac), .analog_mux_select_out(mux), .force_zero_result_out());
  sac_analog_model u_sac_analog_model (.clk_in(clk_in), .arst_n_in(arst_n_in), .rc_on_in(rco), .mux_in(mux),
    .dac_in(dac), .level_in(level), .comparator_out(cmp), .tick_out(tick));
  task automatic wr_reg(input logic [0:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [0:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    // Read data stand for the one cycle after the strobe; take them at its closing edge
    @(posedge clk_in);
    v = rdata;
  endtask
  function automatic logic [7:0] code_for(input logic [3:0] c);
    return c < 4'h6 ? level ^ {4'h0, c} : c == 4'h8 ? 8'hff : c == 4'ha ? 8'h80 : 8'h00;
  endfunction
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    #100us;
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd_reg(1'h0, d);
    `CHK(d, 8'h00)
    wr_reg(1'h0, 8'h25);
    repeat (30) @(posedge clk_in);
    rd_reg(1'h0, d);
    `CHK(d, 8'h25)
    rd_reg(1'h0, d);
    `CHK(d, 8'ha5)
    // Two conversions pass unread with a new input level
    level <= 8'h5a;
    repeat (70) @(posedge clk_in);
    rd_reg(1'h0, d);
    `CHK(d, 8'ha5)
    rd_reg(1'h1, d);
    `CHK(d, 8'h5f)
    rd_reg(1'h0, d);
    `CHK(d, 8'h25)
    wmode <= 1'b1;
    for (int c = 0; c < 13; c++)
    begin
      if (c == 6 || c == 7)
        continue;
      wr_reg(1'h0, 8'h20 | 8'(c));
      rd_reg(1'h0, d);
      `CHK(d, 8'h20 | 8'(c))
      repeat (40) @(posedge clk_in);
      rd_reg(1'h0, d);
      `CHK(d, 8'ha0 | 8'(c))
      `CHK(dig, c < 6 ? pins & ~(8'h01 << c) : pins)
      rd_reg(1'h1, d);
      `CHK(d, code_for(4'(c)))
    end
    wr_reg(1'h0, 8'h15);
    repeat (40) @(posedge clk_in);
    rd_reg(1'h0, d);
    `CHK(d, 8'h05)
    `CHK(dig, pins)
    wr_reg(1'h0, 8'h65);
    repeat (60) @(posedge clk_in);
    rd_reg(1'h0, d);
    `CHK(d, 8'h65)
    `CHK(rco, 1'b1)
    repeat (80) @(posedge clk_in);
    rd_reg(1'h0, d);
    `CHK(d, 8'he5)
    wr_reg(1'h0, 8'h45);
    rd_reg(1'h0, d);
    `CHK(rco, 1'b0)
    wr_reg(1'h0, 8'h00);
    // Reset with the converter switched off clears control but must leave the last result in place
    arst_n_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd_reg(1'h0, d);
    `CHK(d, 8'h00)
    rd_reg(1'h1, d);
    `CHK(d, 8'h5f)
    tally_and_finish();
  end
endmodule // sac_adc_control_tb
